// ===== include/rrte_cfg.svh
// constants for the register/ram transfer execution block
// assumes one 10-bit instruction word per instruction cycle
`ifndef RRTE_CFG_SVH
`define RRTE_CFG_SVH
// full one-word opcodes
`define RRTE_OP_B_TO_ACC 10'h01e
`define RRTE_OP_ACC_TO_B 10'h00e
`define RRTE_OP_Y_TO_ACC 10'h01f
`define RRTE_OP_ACC_TO_Y 10'h00c
`define RRTE_OP_PACK_E 10'h01a
`define RRTE_OP_UNPACK_E 10'h02a
`define RRTE_OP_ACC_TO_PAGE 10'h029
`define RRTE_OP_PAGE_TO_ACC 10'h051
`define RRTE_OP_BANK_TO_ACC 10'h053
`define RRTE_OP_FILE_TO_ACC 10'h052
`define RRTE_OP_SP_TO_ACC 10'h050
`define RRTE_OP_COL_INC 10'h013
`define RRTE_OP_COL_DEC 10'h017
// prefixes of opcodes that carry an immediate
`define RRTE_PFX_READ_RAM 6'h2c
`define RRTE_PFX_SWAP_RAM 6'h2d
`define RRTE_PFX_SWAP_DEC 6'h2f
`define RRTE_PFX_SWAP_INC 6'h2e
`define RRTE_PFX_WRITE_RAM 6'h2b
`define RRTE_PFX_LOAD_ACC 6'h07
`define RRTE_PFX_LOAD_XY 2'h3
`define RRTE_PFX_LOAD_BANK 8'h12
`define RRTE_PFX_TABLE 4'h2
// column values that trigger a skip, and the column step of one
`define RRTE_COL_WRAP_UP 4'h0
`define RRTE_COL_WRAP_DN 4'hf
`define RRTE_NIBBLE_ONE 4'h1
`endif

// ===== include/rrte_pkg.sv
// types shared by the transfer execution block
// no assumptions beyond the cfg header
package rrte_pkg;
   typedef enum {
      OP_NONE, OP_B_TO_ACC, OP_ACC_TO_B, OP_Y_TO_ACC, OP_ACC_TO_Y,
      OP_PACK_E, OP_UNPACK_E, OP_ACC_TO_PAGE, OP_PAGE_TO_ACC,
      OP_BANK_TO_ACC, OP_FILE_TO_ACC, OP_SP_TO_ACC, OP_LOAD_XY,
      OP_LOAD_BANK, OP_COL_INC, OP_COL_DEC, OP_READ_RAM, OP_SWAP_RAM,
      OP_SWAP_DEC, OP_SWAP_INC, OP_WRITE_RAM, OP_LOAD_ACC, OP_TABLE
   } rrte_op_e;
   typedef enum {ST_IDLE, ST_FETCH, ST_RETURN} rrte_state_e;
endpackage : rrte_pkg

// ===== design/rrte_ram.sv
// data ram, 4-bit words addressed by the data pointer
// asynchronous read, write on the clock edge
`timescale 1ns/1ps
module rrte_ram #(
   parameter int ADDR_W = 10
) (
   input wire logic clk,
   input wire logic writeEn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [3:0] writeData,
   output logic [3:0] readData
);
   logic [3:0] mem [2**ADDR_W];

   always_ff @(posedge clk)
   begin
      if (writeEn)
      begin
         mem[addr] <= writeData;
      end
   end

   assign readData = mem[addr];
endmodule : rrte_ram

// ===== design/rrte_stack.sv
// return stack used by the table lookup
// one write port and one asynchronous read port
`timescale 1ns/1ps
module rrte_stack #(
   parameter int PTR_W = 3,
   parameter int PC_W = 13
) (
   input wire logic clk,
   input wire logic writeEn,
   input wire logic [PTR_W-1:0] writeAddr,
   input wire logic [PC_W-1:0] writeData,
   input wire logic [PTR_W-1:0] readAddr,
   output logic [PC_W-1:0] readData
);
   logic [PC_W-1:0] mem [2**PTR_W];

   always_ff @(posedge clk)
   begin
      if (writeEn)
      begin
         mem[writeAddr] <= writeData;
      end
   end

   assign readData = mem[readAddr];
endmodule : rrte_stack

// ===== design/rrte_core.sv
// execution of transfer, ram address, ram access and table lookup ops
// assumes a combinational program rom and a fetch unit that supplies
// the current pc and obeys pcLoad; instructions offered while busy
// are ignored
// Function
// RULE_01: accumulator and B copy, source kept
// RULE_02: accumulator and Y copy, source kept
// RULE_03: pack A,B into E; unpack back
// RULE_04: B is E high, A is E low
// RULE_05: accumulator copied to and from D
// RULE_06: D takes A[2:0]; reading clears A3
// RULE_07: Z copied into accumulator
// RULE_08: upper accumulator bits zero on narrow copies
// RULE_09: X copied into accumulator
// RULE_10: stack pointer copied, pointer unchanged
// RULE_11: immediate load writes X and Y together
// RULE_12: back-to-back X/Y loads: only first runs
// RULE_13: bank load writes immediate into Z
// RULE_14: Y increment, skip when zero
// RULE_15: Y decrement, skip when fifteen
// RULE_16: ram read into A, X xor immediate
// RULE_17: ram swap with A, X xor immediate
// RULE_18: swap variant also decrements Y
// RULE_19: skip after that variant if Y fifteen
// RULE_20: swap variant also increments Y
// RULE_21: skip after that variant if Y zero
// RULE_22: ram write from A, X xor immediate
// RULE_23: immediate constant loaded into accumulator
// RULE_24: table lookup three cycles, push pc
// RULE_25: rom address is page, D, A
// RULE_26: rom word split into holder, B, A
// RULE_27: restore pc, then pop stack pointer
// RULE_28: other ops finish in one cycle
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module rrte_core #(
   parameter int PC_W = 13,
   parameter int PAGE_W = 6,
   parameter int SP_W = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic instrValid,
   input wire logic [9:0] instrWord,
   input wire logic [PC_W-1:0] pcIn,
   input wire logic [9:0] romData,
   output logic [3:0] accQ,
   output logic [3:0] regBQ,
   output logic [3:0] regXQ,
   output logic [3:0] regYQ,
   output logic [1:0] regZQ,
   output logic [2:0] regDQ,
   output logic [7:0] regEQ,
   output logic [SP_W-1:0] stackPtrQ,
   output logic [1:0] romHighQ,
   output logic skipNextQ,
   output logic skippedQ,
   output logic busyQ,
   output logic romReadQ,
   output logic [PAGE_W+6:0] romAddrQ,
   output logic pcLoadQ,
   output logic [PC_W-1:0] pcLoadValueQ
);
   rrte_pkg::rrte_op_e op;
   rrte_pkg::rrte_state_e stateQ;
   logic lastLoadXyQ;
   logic isLoadXy;
   logic exec;
   logic [3:0] imm;
   logic [3:0] yInc;
   logic [3:0] yDec;
   logic [3:0] ramRead;
   logic ramWrite;
   logic [PC_W-1:0] stackRead;
   logic [SP_W-1:0] spInc;

   default clocking cbMain @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   assign imm = instrWord[3:0];
   assign yInc = regYQ + `RRTE_NIBBLE_ONE;
   assign yDec = regYQ - `RRTE_NIBBLE_ONE;
   assign spInc = stackPtrQ + SP_W'(1);

   always_comb
   begin
      op = rrte_pkg::OP_NONE;
      case (instrWord[9:4])
         `RRTE_PFX_READ_RAM: op = rrte_pkg::OP_READ_RAM;
         `RRTE_PFX_SWAP_RAM: op = rrte_pkg::OP_SWAP_RAM;
         `RRTE_PFX_SWAP_DEC: op = rrte_pkg::OP_SWAP_DEC;
         `RRTE_PFX_SWAP_INC: op = rrte_pkg::OP_SWAP_INC;
         `RRTE_PFX_WRITE_RAM: op = rrte_pkg::OP_WRITE_RAM;
         `RRTE_PFX_LOAD_ACC: op = rrte_pkg::OP_LOAD_ACC;
         default:
            case (instrWord)
               `RRTE_OP_B_TO_ACC: op = rrte_pkg::OP_B_TO_ACC;
               `RRTE_OP_ACC_TO_B: op = rrte_pkg::OP_ACC_TO_B;
               `RRTE_OP_Y_TO_ACC: op = rrte_pkg::OP_Y_TO_ACC;
               `RRTE_OP_ACC_TO_Y: op = rrte_pkg::OP_ACC_TO_Y;
               `RRTE_OP_PACK_E: op = rrte_pkg::OP_PACK_E;
               `RRTE_OP_UNPACK_E: op = rrte_pkg::OP_UNPACK_E;
               `RRTE_OP_ACC_TO_PAGE: op = rrte_pkg::OP_ACC_TO_PAGE;
               `RRTE_OP_PAGE_TO_ACC: op = rrte_pkg::OP_PAGE_TO_ACC;
               `RRTE_OP_BANK_TO_ACC: op = rrte_pkg::OP_BANK_TO_ACC;
               `RRTE_OP_FILE_TO_ACC: op = rrte_pkg::OP_FILE_TO_ACC;
               `RRTE_OP_SP_TO_ACC: op = rrte_pkg::OP_SP_TO_ACC;
               `RRTE_OP_COL_INC: op = rrte_pkg::OP_COL_INC;
               `RRTE_OP_COL_DEC: op = rrte_pkg::OP_COL_DEC;
               default: op = rrte_pkg::OP_NONE;
            endcase
      endcase
      if (instrWord[9:2] == `RRTE_PFX_LOAD_BANK)
         op = rrte_pkg::OP_LOAD_BANK;
      if (instrWord[9:6] == `RRTE_PFX_TABLE)
         op = rrte_pkg::OP_TABLE;
      if (instrWord[9:8] == `RRTE_PFX_LOAD_XY)
         op = rrte_pkg::OP_LOAD_XY;
   end

   assign isLoadXy = (op == rrte_pkg::OP_LOAD_XY);
   // a pending skip or a repeated x/y load discards the word
   assign exec = instrValid && (stateQ == rrte_pkg::ST_IDLE) &&
                 !skipNextQ && !(isLoadXy && lastLoadXyQ); // RULE_12
   assign ramWrite = exec && (op == rrte_pkg::OP_WRITE_RAM ||
                     op == rrte_pkg::OP_SWAP_RAM ||
                     op == rrte_pkg::OP_SWAP_DEC ||
                     op == rrte_pkg::OP_SWAP_INC);

   rrte_ram #(.ADDR_W(10)) rrte_ram_inst (
      .clk(clk),
      .writeEn(ramWrite), // RULE_17
      .addr({regZQ, regXQ, regYQ}),
      .writeData(accQ), // RULE_22
      .readData(ramRead)
   );

   rrte_stack #(.PTR_W(SP_W), .PC_W(PC_W)) rrte_stack_inst (
      .clk(clk),
      .writeEn(exec && op == rrte_pkg::OP_TABLE), // RULE_24
      .writeAddr(spInc),
      .writeData(pcIn),
      .readAddr(stackPtrQ),
      .readData(stackRead)
   );

   // run tracking: any offered word in idle, executed or skipped
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         lastLoadXyQ <= 1'b0;
      else if (instrValid && stateQ == rrte_pkg::ST_IDLE)
         lastLoadXyQ <= isLoadXy; // RULE_12
   end
   a_xy_repeat_skip: assert property ( // RULE_12
      lastLoadXyQ && instrValid && isLoadXy && stateQ == rrte_pkg::ST_IDLE
      |=> skippedQ && $stable(regXQ))
      else $error("repeated x/y load executed");

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         skipNextQ <= 1'b0;
         skippedQ <= 1'b0;
      end
      else
      begin
         skippedQ <= instrValid && stateQ == rrte_pkg::ST_IDLE && !exec;
         if (instrValid && stateQ == rrte_pkg::ST_IDLE && !exec)
            skipNextQ <= 1'b0;
         else if (exec)
         begin
            unique case (op)
               rrte_pkg::OP_COL_INC, rrte_pkg::OP_SWAP_INC:
                  skipNextQ <= (yInc == `RRTE_COL_WRAP_UP); // RULE_14 RULE_21
               rrte_pkg::OP_COL_DEC, rrte_pkg::OP_SWAP_DEC:
                  skipNextQ <= (yDec == `RRTE_COL_WRAP_DN); // RULE_15 RULE_19
               default:
                  skipNextQ <= 1'b0;
            endcase
         end
      end
   end
   a_inc_skip: assert property ( // RULE_14
      exec && op == rrte_pkg::OP_COL_INC |=>
      skipNextQ == (regYQ == `RRTE_COL_WRAP_UP))
      else $error("increment skip wrong");
   a_dec_skip: assert property ( // RULE_19
      exec && op == rrte_pkg::OP_SWAP_DEC |=>
      skipNextQ == (regYQ == `RRTE_COL_WRAP_DN))
      else $error("swap decrement skip wrong");

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         accQ <= 4'h0;
      else if (stateQ == rrte_pkg::ST_FETCH)
         accQ <= romData[3:0]; // RULE_26
      else if (exec)
      begin
         unique case (op)
            rrte_pkg::OP_B_TO_ACC: accQ <= regBQ; // RULE_01
            rrte_pkg::OP_Y_TO_ACC: accQ <= regYQ; // RULE_02
            rrte_pkg::OP_UNPACK_E: accQ <= regEQ[3:0]; // RULE_03 RULE_04
            rrte_pkg::OP_PAGE_TO_ACC: accQ <= {1'b0, regDQ}; // RULE_06
            rrte_pkg::OP_BANK_TO_ACC: accQ <= {2'h0, regZQ}; // RULE_07 RULE_08
            rrte_pkg::OP_FILE_TO_ACC: accQ <= regXQ; // RULE_09
            rrte_pkg::OP_SP_TO_ACC:
               accQ <= {{(4-SP_W){1'b0}}, stackPtrQ}; // RULE_10 RULE_08
            rrte_pkg::OP_READ_RAM, rrte_pkg::OP_SWAP_RAM,
            rrte_pkg::OP_SWAP_DEC, rrte_pkg::OP_SWAP_INC:
               accQ <= ramRead; // RULE_16 RULE_17
            rrte_pkg::OP_LOAD_ACC: accQ <= imm; // RULE_23
            default: accQ <= accQ;
         endcase
      end
   end
   a_page_read: assert property ( // RULE_06
      exec && op == rrte_pkg::OP_PAGE_TO_ACC |=> !accQ[3])
      else $error("accumulator bit 3 not cleared");

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regBQ <= 4'h0;
      else if (stateQ == rrte_pkg::ST_FETCH)
         regBQ <= romData[7:4]; // RULE_26
      else if (exec && op == rrte_pkg::OP_ACC_TO_B)
         regBQ <= accQ; // RULE_01
      else if (exec && op == rrte_pkg::OP_UNPACK_E)
         regBQ <= regEQ[7:4]; // RULE_04
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regEQ <= 8'h00;
      else if (exec && op == rrte_pkg::OP_PACK_E)
         regEQ <= {regBQ, accQ}; // RULE_03 RULE_04
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regDQ <= 3'h0;
      else if (exec && op == rrte_pkg::OP_ACC_TO_PAGE)
         regDQ <= accQ[2:0]; // RULE_05 RULE_06
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regZQ <= 2'h0;
      else if (exec && op == rrte_pkg::OP_LOAD_BANK)
         regZQ <= instrWord[1:0]; // RULE_13
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regXQ <= 4'h0;
      else if (exec)
      begin
         unique case (op)
            rrte_pkg::OP_LOAD_XY: regXQ <= instrWord[7:4]; // RULE_11
            rrte_pkg::OP_READ_RAM, rrte_pkg::OP_SWAP_RAM,
            rrte_pkg::OP_SWAP_DEC, rrte_pkg::OP_SWAP_INC,
            rrte_pkg::OP_WRITE_RAM:
               regXQ <= regXQ ^ imm; // RULE_16 RULE_17 RULE_22
            default: regXQ <= regXQ;
         endcase
      end
   end
   a_xor_update: assert property ( // RULE_16
      exec && op == rrte_pkg::OP_READ_RAM |=>
      regXQ == ($past(regXQ) ^ $past(imm)))
      else $error("x xor update wrong");

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         regYQ <= 4'h0;
      else if (exec)
      begin
         unique case (op)
            rrte_pkg::OP_LOAD_XY: regYQ <= imm; // RULE_11
            rrte_pkg::OP_ACC_TO_Y: regYQ <= accQ; // RULE_02
            rrte_pkg::OP_COL_INC, rrte_pkg::OP_SWAP_INC:
               regYQ <= yInc; // RULE_14 RULE_20
            rrte_pkg::OP_COL_DEC, rrte_pkg::OP_SWAP_DEC:
               regYQ <= yDec; // RULE_15 RULE_18
            default: regYQ <= regYQ;
         endcase
      end
   end

   // table lookup: push and address, fetch and split, restore and pop
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         stateQ <= rrte_pkg::ST_IDLE;
         busyQ <= 1'b0;
         romReadQ <= 1'b0;
         romAddrQ <= '0;
         romHighQ <= 2'h0;
         stackPtrQ <= '0;
         pcLoadQ <= 1'b0;
         pcLoadValueQ <= '0;
      end
      else
      begin
         pcLoadQ <= 1'b0;
         romReadQ <= 1'b0;
         unique case (stateQ)
            rrte_pkg::ST_IDLE:
               if (exec && op == rrte_pkg::OP_TABLE)
               begin
                  stackPtrQ <= spInc; // RULE_24
                  romAddrQ <= {instrWord[PAGE_W-1:0], regDQ, accQ}; // RULE_25
                  romReadQ <= 1'b1;
                  busyQ <= 1'b1;
                  stateQ <= rrte_pkg::ST_FETCH;
               end
            rrte_pkg::ST_FETCH:
            begin
               romHighQ <= romData[9:8]; // RULE_26
               stateQ <= rrte_pkg::ST_RETURN;
            end
            rrte_pkg::ST_RETURN:
            begin
               pcLoadQ <= 1'b1; // RULE_27
               pcLoadValueQ <= stackRead;
               stackPtrQ <= stackPtrQ - SP_W'(1);
               busyQ <= 1'b0;
               stateQ <= rrte_pkg::ST_IDLE;
            end
         endcase
      end
   end

   sequence s_table_start;
      exec && op == rrte_pkg::OP_TABLE;
   endsequence
   sequence s_table_body;
      busyQ && romReadQ ##1 busyQ && !romReadQ ##1 !busyQ && pcLoadQ;
   endsequence

   a_table_cycles: assert property (s_table_start |=> s_table_body) // RULE_24
      else $error("table lookup sequence wrong");
   a_table_sp_restore: assert property (s_table_start |-> ##3 // RULE_27
      stackPtrQ == $past(stackPtrQ, 3))
      else $error("stack pointer not restored");
   a_table_rom_addr: assert property (s_table_start |=> // RULE_25
      romAddrQ == {$past(instrWord[PAGE_W-1:0]), $past(regDQ), $past(accQ)})
      else $error("rom address wrong");
   a_table_split: assert property (stateQ == rrte_pkg::ST_FETCH |=> // RULE_26
      {romHighQ, regBQ, accQ} == $past(romData))
      else $error("rom word split wrong");
   a_single_cycle: assert property ( // RULE_28
      exec && op != rrte_pkg::OP_TABLE |=> !busyQ)
      else $error("one-cycle op left block busy");
endmodule : rrte_core

// ===== verif/register_ram_transfer_exec_test.sv
// self-checking bench for the transfer execution core
// assumes rrte_core with default parameters and its internal ram/stack
`timescale 1ns/1ps
`include "rrte_cfg.svh"
module register_ram_transfer_exec_test;
   logic clk;
   logic reset_n;
   logic instrValid;
   logic [9:0] instrWord;
   logic [12:0] pcIn;
   logic [9:0] romData;
   logic [3:0] accQ;
   logic [3:0] regBQ;
   logic [3:0] regXQ;
   logic [3:0] regYQ;
   logic [1:0] regZQ;
   logic [2:0] regDQ;
   logic [7:0] regEQ;
   logic [2:0] stackPtrQ;
   logic [1:0] romHighQ;
   logic skipNextQ;
   logic skippedQ;
   logic busyQ;
   logic romReadQ;
   logic [12:0] romAddrQ;
   logic pcLoadQ;
   logic [12:0] pcLoadValueQ;
   int nErrors = 0;
   int nCompared = 0;

   rrte_core rrte_core_inst (
      .clk(clk), .reset_n(reset_n), .instrValid(instrValid),
      .instrWord(instrWord), .pcIn(pcIn), .romData(romData),
      .accQ(accQ), .regBQ(regBQ), .regXQ(regXQ), .regYQ(regYQ),
      .regZQ(regZQ), .regDQ(regDQ), .regEQ(regEQ),
      .stackPtrQ(stackPtrQ), .romHighQ(romHighQ),
      .skipNextQ(skipNextQ), .skippedQ(skippedQ), .busyQ(busyQ),
      .romReadQ(romReadQ), .romAddrQ(romAddrQ), .pcLoadQ(pcLoadQ),
      .pcLoadValueQ(pcLoadValueQ)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [12:0] seen,
                      input logic [12:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // offers one word; valid stays high so back-to-back words work
   task automatic issue(input logic [9:0] w);
      instrWord = w;
      instrValid = 1'b1;
      @(posedge clk);
      #1;
   endtask : issue

   task automatic idle();
      instrValid = 1'b0;
      @(posedge clk);
      #1;
   endtask : idle

   function automatic logic [9:0] loadXy(input logic [3:0] x,
                                         input logic [3:0] y);
      return {`RRTE_PFX_LOAD_XY, x, y};
   endfunction : loadXy

   function automatic logic [9:0] loadAcc(input logic [3:0] n);
      return {`RRTE_PFX_LOAD_ACC, n};
   endfunction : loadAcc

   task automatic endSim();
      $display("compared %0d mismatches %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : endSim

   task automatic tCopies();
      issue(loadAcc(4'h5));
      chk("acc", accQ, 13'h5);
      issue(`RRTE_OP_ACC_TO_B);
      chk("b", regBQ, 13'h5);
      issue(loadAcc(4'ha));
      issue(`RRTE_OP_ACC_TO_Y);
      chk("y", regYQ, 13'ha);
      chk("acc", accQ, 13'ha);
      issue(`RRTE_OP_B_TO_ACC);
      chk("acc", accQ, 13'h5);
      chk("b", regBQ, 13'h5);
      issue(`RRTE_OP_Y_TO_ACC);
      chk("acc", accQ, 13'ha);
      chk("y", regYQ, 13'ha);
      idle();
      $display("test copies done");
   endtask : tCopies

   task automatic tPackE();
      issue(loadAcc(4'h3));
      issue(`RRTE_OP_ACC_TO_B);
      issue(loadAcc(4'hc));
      issue(`RRTE_OP_PACK_E);
      chk("e", regEQ, 13'h3c);
      issue(loadAcc(4'h0));
      issue(`RRTE_OP_ACC_TO_B);
      issue(`RRTE_OP_UNPACK_E);
      chk("b", regBQ, 13'h3);
      chk("acc", accQ, 13'hc);
      idle();
      $display("test pack done");
   endtask : tPackE

   task automatic tNarrow();
      issue(loadAcc(4'hf));
      issue(`RRTE_OP_ACC_TO_PAGE);
      chk("d", regDQ, 13'h7);
      issue(loadAcc(4'h0));
      issue(`RRTE_OP_PAGE_TO_ACC);
      chk("acc", accQ, 13'h7);
      issue({`RRTE_PFX_LOAD_BANK, 2'h3});
      chk("z", regZQ, 13'h3);
      issue(loadAcc(4'hf));
      issue(`RRTE_OP_BANK_TO_ACC);
      chk("acc", accQ, 13'h3);
      issue(loadAcc(4'hf));
      issue(`RRTE_OP_SP_TO_ACC);
      chk("acc", accQ, 13'h0);
      chk("sp", stackPtrQ, 13'h0);
      idle();
      $display("test narrow done");
   endtask : tNarrow

   task automatic tLoadXy();
      issue(loadXy(4'h9, 4'h4));
      chk("x", regXQ, 13'h9);
      chk("y", regYQ, 13'h4);
      issue(loadXy(4'h1, 4'h2));
      chk("skipped", skippedQ, 13'h1);
      chk("x", regXQ, 13'h9);
      issue(loadAcc(4'h0));
      issue(loadXy(4'h1, 4'h2));
      chk("y", regYQ, 13'h2);
      issue(`RRTE_OP_FILE_TO_ACC);
      chk("acc", accQ, 13'h1);
      idle();
      $display("test load xy done");
   endtask : tLoadXy

   task automatic tColumn();
      issue(loadAcc(4'h5));
      issue(loadXy(4'h0, 4'hf));
      issue(`RRTE_OP_COL_INC);
      chk("y", regYQ, 13'h0);
      chk("skip", skipNextQ, 13'h1);
      issue(loadAcc(4'h9));
      chk("skipped", skippedQ, 13'h1);
      chk("acc", accQ, 13'h5);
      issue(`RRTE_OP_COL_DEC);
      chk("y", regYQ, 13'hf);
      chk("skip", skipNextQ, 13'h1);
      issue(loadAcc(4'h9));
      issue(`RRTE_OP_COL_DEC);
      chk("y", regYQ, 13'he);
      chk("skip", skipNextQ, 13'h0);
      idle();
      $display("test column done");
   endtask : tColumn

   task automatic tRam();
      issue(loadXy(4'h2, 4'h3));
      issue(loadAcc(4'h6));
      issue({`RRTE_PFX_WRITE_RAM, 4'h5});
      chk("x", regXQ, 13'h7);
      issue(loadXy(4'h2, 4'h3));
      issue({`RRTE_PFX_READ_RAM, 4'h0});
      chk("acc", accQ, 13'h6);
      issue(loadAcc(4'h9));
      issue({`RRTE_PFX_SWAP_RAM, 4'h0});
      chk("acc", accQ, 13'h6);
      issue({`RRTE_PFX_READ_RAM, 4'hf});
      chk("acc", accQ, 13'h9);
      chk("x", regXQ, 13'hd);
      issue(loadXy(4'h2, 4'h0));
      issue(loadAcc(4'h4));
      issue({`RRTE_PFX_WRITE_RAM, 4'h0});
      issue(loadAcc(4'h1));
      issue({`RRTE_PFX_SWAP_DEC, 4'h1});
      chk("acc", accQ, 13'h4);
      chk("x", regXQ, 13'h3);
      chk("y", regYQ, 13'hf);
      chk("skip", skipNextQ, 13'h1);
      issue(loadAcc(4'h8));
      chk("skipped", skippedQ, 13'h1);
      issue(loadAcc(4'h7));
      issue({`RRTE_PFX_WRITE_RAM, 4'h0});
      issue(loadAcc(4'h2));
      issue({`RRTE_PFX_SWAP_INC, 4'h0});
      chk("acc", accQ, 13'h7);
      chk("y", regYQ, 13'h0);
      chk("skip", skipNextQ, 13'h1);
      issue(loadAcc(4'h8));
      chk("acc", accQ, 13'h7);
      idle();
      $display("test ram done");
   endtask : tRam

   task automatic tTable();
      issue(loadAcc(4'h5));
      issue(`RRTE_OP_ACC_TO_PAGE);
      issue(loadAcc(4'ha));
      issue({`RRTE_PFX_TABLE, 6'h2d});
      // a word offered while busy must be ignored until busy drops
      instrWord = loadAcc(4'hf);
      chk("busy", busyQ, 13'h1);
      chk("romread", romReadQ, 13'h1);
      chk("sp", stackPtrQ, 13'h1);
      chk("romaddr", romAddrQ, {6'h2d, 3'h5, 4'ha});
      @(posedge clk);
      #1;
      chk("romread", romReadQ, 13'h0);
      chk("acc", accQ, 13'h7);
      chk("b", regBQ, 13'hb);
      chk("high", romHighQ, 13'h2);
      @(posedge clk);
      #1;
      chk("busy", busyQ, 13'h0);
      chk("pcload", pcLoadQ, 13'h1);
      chk("pcvalue", pcLoadValueQ, 13'h1234);
      chk("sp", stackPtrQ, 13'h0);
      chk("acc", accQ, 13'h7);
      @(posedge clk);
      #1;
      chk("pcload", pcLoadQ, 13'h0);
      chk("acc", accQ, 13'hf);
      idle();
      $display("test table done");
   endtask : tTable

   initial
   begin
      reset_n = 1'b0;
      instrValid = 1'b0;
      instrWord = 10'h000;
      pcIn = 13'h1234;
      romData = 10'h2b7;
      repeat (8) @(posedge clk);
      #1;
      reset_n = 1'b1;
      tCopies();
      tPackE();
      tNarrow();
      tLoadXy();
      tColumn();
      tRam();
      tTable();
      endSim();
   end

   // watchdog: the whole run needs well under 200 cycles
   initial
   begin
      #20000;
      nErrors++;
      endSim();
   end
endmodule : register_ram_transfer_exec_test
